// ---- logic/ubg_majority.sv ----
module ubg_majority
  import ubg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  ubg_vote_if.voter vote
);

  logic [VOTE_N-1:0] hist_q;
  logic              level_q;
  logic [1:0]        ones;

  // last three samples of the line; idle line is high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hist_q <= '1;
    end else if (vote.sample_en) begin
      hist_q <= {hist_q[VOTE_N-2:0], vote.line_raw};
    end
  end

  always_comb begin
    ones = 2'(hist_q[0]) + 2'(hist_q[1]) + 2'(hist_q[2]);
  end

  // two of three wins, so a single glitch sample cannot flip the level
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      level_q <= 1'b1;
    end else begin
      level_q <= (ones >= 2'h2);
    end
  end

  assign vote.level = level_q;

endmodule // ubg_majority

// ---- logic/ubg_pkg.sv ----
package ubg_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] RCV_CTRL_OFS = 8'h18; // receive_status_control
  localparam logic [7:0] XMT_CTRL_OFS = 8'h98; // transmit_status_control
  localparam logic [7:0] BAUD_DIV_OFS = 8'h99; // baud_divisor

  // transmit_status_control fields
  localparam int unsigned XMT_CLK_SRC_BIT = 7; // 1 = clock master (internal)
  localparam int unsigned XMT_NINE_BIT    = 6;
  localparam int unsigned XMT_EN_BIT      = 5;
  localparam int unsigned XMT_SYNC_BIT    = 4; // clocked mode select
  localparam int unsigned XMT_HIGH_SPD    = 2; // high_speed_select
  localparam int unsigned XMT_SHIFT_EMPTY = 1; // read only
  localparam int unsigned XMT_NINTH_BIT   = 0;

  // receive_status_control fields
  localparam int unsigned RCV_PORT_EN_BIT = 7;
  localparam int unsigned RCV_NINE_BIT    = 6;
  localparam int unsigned RCV_SINGLE_BIT  = 5; // single_receive_enable
  localparam int unsigned RCV_CONT_BIT    = 4; // continuous_receive_enable
  localparam int unsigned RCV_FRAME_BIT   = 2; // framing_error_flag, read only
  localparam int unsigned RCV_OVERRUN_BIT = 1; // overrun_error_flag, read only
  localparam int unsigned RCV_NINTH_BIT   = 0; // receive_ninth_bit, read only

  // reset values
  localparam logic [7:0] XMT_CTRL_RST = 8'h02;
  localparam logic [7:0] RCV_CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_DIV_RST = 8'h00;

  // writable masks; unimplemented and read-only bits are never stored
  localparam logic [7:0] XMT_CTRL_WMASK = 8'hF5;
  localparam logic [7:0] RCV_CTRL_WMASK = 8'hF0;

  // sample ticks per bit, minus one (the terminal count of the post divider)
  localparam logic [5:0] POST_TERM_LOW  = 6'h3F; // 64 samples per bit
  localparam logic [5:0] POST_TERM_HIGH = 6'h0F; // 16 samples per bit
  localparam logic [5:0] POST_TERM_SYNC = 6'h03; // 4 sample ticks per bit

  // number of samples that vote on the receive line
  localparam int unsigned VOTE_N = 3;

  typedef enum logic [1:0] {
    UBG_ASYNC_LOW,
    UBG_ASYNC_HIGH,
    UBG_SYNC_MASTER,
    UBG_SYNC_SLAVE
  } ubg_mode_e;

endpackage : ubg_pkg

// ---- logic/ubg_top.sv ----
// Contract
// - one 8-bit tick generator serves all modes except the clocked slave
// - divisor sets free-running 8-bit timer period
// - async mode: high speed bit shapes rate
// - sync mode ignores high speed bit
// - async low: clock over 64 times (X+1)
// - async high: clock over 16 times (X+1)
// - sync: clock over 4 times (X+1)
// - formulas only as master; slave uses external clock
// - every divisor 0..255 gives valid period
// - divisor write restarts the timer at once
// - receive line decided by three-sample majority
// - timer gives x16, x64 or (clocked) x4 sample clock
// - clocked mode bit clear selects async
module ubg_top
  import ubg_pkg::*;
#(
  parameter int unsigned DIV_W = 8
) (
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  // register port
  input  wire logic [ubg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ubg_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [ubg_pkg::DATA_W-1:0] reg_rdata,
  // status from the transmitter and receiver
  input  wire logic                      shift_empty,
  input  wire logic                      framing_error_flag,
  input  wire logic                      overrun_error_flag,
  input  wire logic                      receive_ninth_bit,
  // line side
  input  wire logic                      receive_data_pin,
  input  wire logic                      ext_bit_clk,
  // to the shifting and sampling logic
  output logic                           sample_tick,
  output logic                           baud_tick,
  output logic                           rx_level,
  output logic                           sync_mode,
  output logic                           port_enable
);

  // the register is 8 bits wide, so the timer cannot be any other width
  if (DIV_W != DATA_W) begin : g_div_w_check
    $error("ubg_top: DIV_W must equal the 8-bit register width");
  end

  // the voter below taps exactly three samples of the line
  if (VOTE_N != 3) begin : g_vote_n_check
    $error("ubg_top: VOTE_N must be 3");
  end

  // register state
  // only writable bits are stored, so unused bits read back as zero
  logic [7:0]       xmt_ctrl_q;
  logic [7:0]       rcv_ctrl_q;
  logic [DIV_W-1:0] baud_divisor_q;
  logic [7:0]       reg_rdata_q;

  // one write enable per register
  logic             wr_xmt;
  logic             wr_rcv;
  logic             wr_div;

  // address decode of the write strobe
  // exact decode: any other address neither stores nor disturbs the timer
  always_comb begin
    wr_xmt = reg_wr && (reg_addr == XMT_CTRL_OFS);
    wr_rcv = reg_wr && (reg_addr == RCV_CTRL_OFS);
    wr_div = reg_wr && (reg_addr == BAUD_DIV_OFS);
  end

  // transmit_status_control: only writable bits are stored
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      xmt_ctrl_q <= XMT_CTRL_RST;
    end else if (wr_xmt) begin
      xmt_ctrl_q <= reg_wdata & XMT_CTRL_WMASK;
    end
  end

  // receive_status_control: control half only, flags come from the receiver
  // the flags are read live, so a read never shows a stale flag
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rcv_ctrl_q <= RCV_CTRL_RST;
    end else if (wr_rcv) begin
      rcv_ctrl_q <= reg_wdata & RCV_CTRL_WMASK;
    end
  end

  // baud_divisor: every 8-bit value is accepted as is
  // zero is legal and gives the fastest rate, one sample tick per clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      baud_divisor_q <= BAUD_DIV_RST;
    end else if (wr_div) begin
      baud_divisor_q <= reg_wdata;
    end
  end

  // read path: data stand in the cycle after the strobe only
  // the reply drops back to zero afterwards, so old data never linger
  // flags and the shifter status are read live, never stored
  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    logic [7:0] val;
    val = 8'h00;
    unique case (addr)
      XMT_CTRL_OFS: begin
        val                  = xmt_ctrl_q;
        val[XMT_SHIFT_EMPTY] = shift_empty;
      end
      RCV_CTRL_OFS: begin
        val                  = rcv_ctrl_q;
        val[RCV_FRAME_BIT]   = framing_error_flag;
        val[RCV_OVERRUN_BIT] = overrun_error_flag;
        val[RCV_NINTH_BIT]   = receive_ninth_bit;
      end
      BAUD_DIV_OFS: begin
        val = baud_divisor_q;
      end
      default: begin
        val = 8'h00; // unmapped addresses read as zero
      end
    endcase
    return val;
  endfunction

  // registered reply, zero outside its one cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= read_mux(reg_addr);
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // mode selection
  // high speed select matters only while the clocked mode bit is clear
  ubg_mode_e mode;
  logic [5:0] post_term;

  // clocked mode bit first, then high speed, then clock source
  always_comb begin
    if (!xmt_ctrl_q[XMT_SYNC_BIT]) begin
      if (xmt_ctrl_q[XMT_HIGH_SPD]) begin
        mode = UBG_ASYNC_HIGH;
      end else begin
        mode = UBG_ASYNC_LOW;
      end
    end else if (xmt_ctrl_q[XMT_CLK_SRC_BIT]) begin
      mode = UBG_SYNC_MASTER;
    end else begin
      mode = UBG_SYNC_SLAVE;
    end
  end

  // samples per bit for each mode
  // the rate choice itself is left to software; x16 often has less error
  always_comb begin
    unique case (mode)
      UBG_ASYNC_LOW:   post_term = POST_TERM_LOW;
      UBG_ASYNC_HIGH:  post_term = POST_TERM_HIGH;
      UBG_SYNC_MASTER: post_term = POST_TERM_SYNC;
      UBG_SYNC_SLAVE:  post_term = POST_TERM_SYNC;
    endcase
  end

  // divisor timer: the one generator shared by the async modes and the clocked master; the slave does not use it
  // eight bits wide, so the longest timer period is 256 clocks
  logic [DIV_W-1:0] timer_q;
  logic             timer_wrap;

  // a timer above the divisor cannot stall: the >= compare wraps it at once
  always_comb begin
    timer_wrap = (timer_q >= baud_divisor_q);
  end

  // free running; a divisor write restarts it so the new rate shows
  // without waiting out a long old period
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timer_q <= '0;
    end else if (wr_div) begin
      timer_q <= '0;
    end else if (timer_wrap) begin
      timer_q <= '0;
    end else begin
      timer_q <= timer_q + 1'b1;
    end
  end

  // sample clock: one pulse per timer period, x16, x64 or (clocked master) x4 of the bit rate
  // held low as slave, where no internal sample clock exists
  logic sample_tick_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sample_tick_q <= 1'b0;
    end else begin
      sample_tick_q <= timer_wrap && !wr_div && (mode != UBG_SYNC_SLAVE);
    end
  end

  // post divider: sample clock to bit rate
  // a divisor write restarts it too, so the first bit after it is whole
  // counts sample ticks within one bit
  logic [5:0] post_q;
  logic       post_wrap;

  always_comb begin
    post_wrap = (post_q >= post_term);
  end

  // the >= test also recovers when a mode change shrinks the terminal
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      post_q <= '0;
    end else if (wr_div) begin
      post_q <= '0;
    end else if (sample_tick_q) begin
      if (post_wrap) begin
        post_q <= '0;
      end else begin
        post_q <= post_q + 1'b1;
      end
    end else if (post_wrap && (post_q != post_term)) begin
      post_q <= '0;
    end
  end

  // external bit clock for the slave; inputs are already synchronous
  // the edge detector resets low, the parked level of the far side's clock
  logic ext_clk_q;

  // one flop of history for the rising edge detector
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_clk_q <= 1'b0;
    end else begin
      ext_clk_q <= ext_bit_clk;
    end
  end

  // bit rate tick
  // it lags its sample tick by one cycle, the price of a registered output
  logic baud_tick_q;

  // as slave the far side's rising edge is the tick, else the post divider
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      baud_tick_q <= 1'b0;
    end else if (mode == UBG_SYNC_SLAVE) begin
      baud_tick_q <= ext_bit_clk && !ext_clk_q;
    end else begin
      baud_tick_q <= sample_tick_q && post_wrap && !wr_div;
    end
  end

  // receive line majority detector
  // a single noisy sample cannot flip the decided level
  ubg_vote_if vote_if ();

  // as slave the line is sampled every clock, there is no sample clock
  assign vote_if.sample_en = sample_tick_q || (mode == UBG_SYNC_SLAVE);
  assign vote_if.line_raw  = receive_data_pin;

  // the voter keeps its own history and decided level
  ubg_majority u_majority (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .vote    (vote_if.voter)
  );

  // configuration seen by the transmitter and receiver
  // copies lag the register by one cycle but reach the pins from flip-flops
  logic sync_mode_q;
  logic port_enable_q;

  // mode and enable copies for the transmitter and receiver
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_mode_q   <= 1'b0;
      port_enable_q <= 1'b0;
    end else begin
      sync_mode_q   <= xmt_ctrl_q[XMT_SYNC_BIT];
      port_enable_q <= rcv_ctrl_q[RCV_PORT_EN_BIT];
    end
  end

  // outputs are renames of flip-flops, nothing combinational on the pins
  assign reg_rdata   = reg_rdata_q;
  assign sample_tick = sample_tick_q;
  assign baud_tick   = baud_tick_q;
  assign rx_level    = vote_if.level;
  assign sync_mode   = sync_mode_q;
  assign port_enable = port_enable_q;

endmodule // ubg_top

// ---- logic/ubg_vote_if.sv ----
// carries the sampling strobe and raw line to the voter, and the vote back
interface ubg_vote_if;
  logic sample_en;
  logic line_raw;
  logic level;

  modport ctrl  (output sample_en, output line_raw, input level);
  modport voter (input sample_en, input line_raw, output level);
endinterface : ubg_vote_if

// ---- tb/tb_usart_baud_rate_generator.sv ----
module tb_usart_baud_rate_generator import ubg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, resetn, reg_wr, reg_rd, shift_empty, arm, rd_d;
  logic        framing_error_flag, overrun_error_flag, receive_ninth_bit;
  logic        receive_data_pin, ext_bit_clk, sample_tick, baud_tick;
  logic        rx_level, sync_mode, port_enable, line_en, line_bit, clk_run;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, x, st;
  logic [15:0] gap;
  logic [7:0]  rd_q[$];
  logic [15:0] per_q[$];
  int          n_fail, checks_done;
  logic [7:0]  modes[6] = '{8'h00, 8'h04, 8'h90, 8'h94, 8'h04, 8'h00};
  int          mult[6] = '{64, 16, 4, 4, 16, 64};

  ubg_top i_ubg_top (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .shift_empty, .framing_error_flag, .overrun_error_flag, .receive_ninth_bit,
    .receive_data_pin, .ext_bit_clk, .sample_tick, .baud_tick, .rx_level, .sync_mode,
    .port_enable);
  ubg_line_model i_ubg_line_model (.ref_clk, .line_en, .line_bit, .clk_run,
    .line(receive_data_pin), .bit_clk(ext_bit_clk));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp=%0h seen=%0h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // strobes stay up across back-to-back cycles; idle drops them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b10, a, d};
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    {reg_wr, reg_rd, reg_addr} <= {2'b01, a};
    @(posedge ref_clk);
  endtask
  task automatic idle();
    {reg_wr, reg_rd} <= 2'b00;
  endtask
  task automatic wait_tick();
    int n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (baud_tick !== 1'b1 && n < 9000);
  endtask
  task automatic measure(input logic [15:0] per);
    per_q.push_back(per);
    wait_tick();
    arm <= 1'b1;
    wait_tick();
    arm <= 1'b0;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // read replies and bit tick spacing are judged against the oldest note
  always @(posedge ref_clk) begin
    if (rd_d) check("reg_rdata", 16'(reg_rdata), 16'(rd_q.pop_front()));
    if (baud_tick === 1'b1) begin
      if (arm) check("bit period", gap, per_q.pop_front());
      gap = 16'h0001;
    end else gap = gap + 16'h0001;
    rd_d = reg_rd;
  end
  // a hang counts as a mismatch
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end
  initial begin
    void'($urandom(52));
    {resetn, reg_wr, reg_rd, arm, rd_d, line_en, line_bit, clk_run} = '0;
    {reg_addr, reg_wdata, gap} = '0;
    shift_empty = 1'b1;
    st = 8'($urandom % 8);
    {framing_error_flag, overrun_error_flag, receive_ninth_bit} = st[2:0];
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    // reset values, write masks and an unmapped place
    rd(XMT_CTRL_OFS, 8'h02);
    rd(RCV_CTRL_OFS, st);
    rd(BAUD_DIV_OFS, 8'h00);
    rd(8'h20, 8'h00);
    check("port_enable", 16'(port_enable), 16'h0000);
    wr(XMT_CTRL_OFS, 8'hFF);
    wr(RCV_CTRL_OFS, 8'hFF);
    wr(8'h20, 8'h5A);
    rd(XMT_CTRL_OFS, 8'hF7);
    rd(RCV_CTRL_OFS, 8'hF0 | st);
    check("port_enable", 16'(port_enable), 16'h0001);
    rd(8'h20, 8'h00);
    // every rate mode, random and boundary divisors, then a restart mid-run
    for (int i = 0; i < 6; i++) begin
      x = (i == 4) ? 8'hFF : (i == 5) ? 8'h00 : 8'($urandom % 8);
      wr(XMT_CTRL_OFS, modes[i]);
      wr(BAUD_DIV_OFS, x);
      rd(BAUD_DIV_OFS, x);
      idle();
      measure(16'(mult[i] * (x + 1)));
      wr(BAUD_DIV_OFS, x); // held back to back into the next mode write
    end
    // slave mode follows the far side's bit clock
    wr(XMT_CTRL_OFS, 8'h10);
    idle();
    repeat (4) @(posedge ref_clk);
    clk_run <= 1'b1;
    measure(16'h0008);
    clk_run <= 1'b0;
    wr(XMT_CTRL_OFS, 8'h00);
    wr(BAUD_DIV_OFS, 8'h00);
    idle();
    // vote: a one-sample glitch must not flip the level
    {line_en, line_bit} <= 2'b10;
    repeat (10) @(posedge ref_clk);
    check("rx_level", 16'(rx_level), 16'h0000);
    line_bit <= 1'b1;
    @(posedge ref_clk);
    line_bit <= 1'b0;
    repeat (6) begin
      @(posedge ref_clk);
      check("rx_level", 16'(rx_level), 16'h0000);
    end
    repeat (40) begin
      line_bit <= 1'($urandom);
      @(posedge ref_clk);
    end
    line_en <= 1'b0;
    repeat (10) @(posedge ref_clk);
    check("rx_level", 16'(rx_level), 16'h0001);
    summarize();
  end
endmodule // tb_usart_baud_rate_generator

// ---- tb/ubg_line_model.sv ----
module ubg_line_model (
  input  wire logic ref_clk,
  input  wire logic line_en,
  input  wire logic line_bit,
  input  wire logic clk_run,
  output logic      line,
  output logic      bit_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ph_q;
  // a released line floats to its idle-high pull-up
  assign line = line_en ? line_bit : 1'b1;
  // bit clock of eight ref clocks, parked low between frames
  always_ff @(posedge ref_clk) begin
    if (!clk_run) ph_q <= 3'h0;
    else ph_q <= ph_q + 3'h1;
  end
  assign bit_clk = clk_run && ph_q[2];
endmodule // ubg_line_model

// ---- tb/ubg_top_checker.sv ----
module ubg_top_checker
  import ubg_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       receive_data_pin,
  input wire logic       ext_bit_clk,
  input wire logic       sample_tick,
  input wire logic       baud_tick,
  input wire logic       rx_level,
  input wire logic       sync_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic       wd, wx, slave, wrap_q, ok_q, seen_q;
  logic [7:0] div_q, tmr_q, xmt_q, cnt_q, term;
  assign wd = reg_wr && reg_addr == BAUD_DIV_OFS;
  assign wx = reg_wr && reg_addr == XMT_CTRL_OFS;
  assign slave = xmt_q[XMT_SYNC_BIT] && !xmt_q[XMT_CLK_SRC_BIT];
  assign term = xmt_q[XMT_SYNC_BIT] ? 8'h03 : (xmt_q[XMT_HIGH_SPD] ? 8'h0F : 8'h3F);
  // shadow timer; untrusted after slave mode until the divisor is rewritten
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_q  <= 8'h00;
      tmr_q  <= 8'h00;
      xmt_q  <= 8'h02;
      wrap_q <= 1'b0;
      ok_q   <= 1'b1;
    end else begin
      if (wd) div_q <= reg_wdata;
      if (wx) xmt_q <= reg_wdata;
      tmr_q  <= (wd || tmr_q == div_q) ? 8'h00 : tmr_q + 8'h01;
      wrap_q <= !wd && tmr_q == div_q;
      ok_q   <= wd || (ok_q && !slave);
    end
  end
  // sample ticks since the last bit tick; a mode write voids the count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= 8'h00;
      seen_q <= 1'b1;
    end else begin
      if (wd) cnt_q <= 8'h00;
      else if (baud_tick) cnt_q <= {7'h00, sample_tick}; // a coincident sample opens the count
      else if (sample_tick) cnt_q <= cnt_q + 8'h01;
      seen_q <= wd || (!wx && (seen_q || baud_tick));
    end
  end
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside reply");
  div_readback_a: assert property (wd ##1 (reg_rd && reg_addr == BAUD_DIV_OFS)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("divisor readback");
  tick_period_a: assert property (ok_q && !slave |-> sample_tick == wrap_q)
    else $error("sample tick timing");
  baud_ratio_a: assert property (baud_tick && seen_q && !slave
    |-> $past(sample_tick) && cnt_q == term + 8'h01) else $error("bit tick ratio");
  sync_follow_a: assert property (wx ##1 !wx
    |=> sync_mode == $past(reg_wdata[XMT_SYNC_BIT], 2)) else $error("sync mode copy");
  slave_tick_a: assert property (slave && $rose(ext_bit_clk) |=> baud_tick)
    else $error("slave bit tick");
  rx_high_a: assert property ((div_q == 8'h00 && receive_data_pin) [*8]
    |-> ##[0:2] rx_level) else $error("vote high");
  rx_low_a: assert property ((div_q == 8'h00 && !receive_data_pin) [*8]
    |-> ##[0:2] !rx_level) else $error("vote low");
endmodule // ubg_top_checker

bind ubg_top ubg_top_checker i_ubg_top_checker (.ref_clk, .resetn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .receive_data_pin, .ext_bit_clk, .sample_tick, .baud_tick,
  .rx_level, .sync_mode);
